// ===== shared/gptg_pkg.sv
package gptg_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int CNT_W         = 16;
   localparam int NUM_W         = 32;
   localparam int GMODE_W       = 3;

   // ------------------------------------------------------------
   // gate modes
   // ------------------------------------------------------------
   localparam logic [2:0] GATE_NONE = 3'h0;
   localparam logic [2:0] GATE_HIGH = 3'h1;
   localparam logic [2:0] GATE_LOW  = 3'h2;
   localparam logic [2:0] GATE_RISE = 3'h3;
   localparam logic [2:0] GATE_FALL = 3'h4;

   // ------------------------------------------------------------
   // counts and reset values
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0] MIN_PHASE     = 16'h0001;
   localparam logic [CNT_W-1:0] MIN_PERIOD    = 16'h0003;
   localparam logic [CNT_W-1:0] RST_DELAY_LEN = 16'h0002;
   localparam logic [CNT_W-1:0] RST_PULSE_LEN = 16'h0002;
   localparam logic [NUM_W-1:0] PULSES_CONT   = 32'h00000000;
   localparam logic [NUM_W-1:0] PULSES_FREE   = 32'hffffffff;

   // ------------------------------------------------------------
   // timebase selection
   // ------------------------------------------------------------
   localparam logic [31:0] TB_INTERNAL_HZ = 32'd10000000;
   localparam logic [31:0] TB_DEFAULT     = 32'h00000000;

   typedef enum logic [1:0]
   {
      GPTG_IDLE  = 2'b00,
      GPTG_ARMED = 2'b01,
      GPTG_DELAY = 2'b10,
      GPTG_PULSE = 2'b11
   } gptg_state_t;

endpackage : gptg_pkg

// ===== hdl/gptg_sync.sv
`timescale 1ns/1ps
module gptg_sync
   import gptg_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic async_in,
   output logic      level_out,
   output logic      rise_out,
   output logic      fall_out
);

   // ------------------------------------------------------------
   // three stages; a change counts when stages two and three agree
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [2:0] sh;
      logic       lvl;
      logic       rise;
      logic       fall;
   } gptg_sync_t;

   gptg_sync_t s_reg;
   gptg_sync_t s_next;

   always_comb
   begin
      s_next      = s_reg;
      s_next.sh   = {s_reg.sh[1:0], async_in};
      s_next.rise = 1'b0;
      s_next.fall = 1'b0;
      if (s_reg.sh[1] == s_reg.sh[2] && s_reg.sh[2] != s_reg.lvl)
      begin
         s_next.lvl  = s_reg.sh[2];
         s_next.rise = s_reg.sh[2];
         s_next.fall = ~s_reg.sh[2];
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign level_out = s_reg.lvl;
   assign rise_out  = s_reg.rise;
   assign fall_out  = s_reg.fall;

endmodule : gptg_sync

// ===== hdl/gptg_top.sv
`timescale 1ns/1ps
module gptg_top
   import gptg_pkg::*;
#(
   parameter int CW = CNT_W,
   parameter int NW = NUM_W
)
(
   input  wire logic          clk_sys,
   input  wire logic          nrst,
   input  wire logic          sw_start,
   input  wire logic          sw_stop,
   input  wire logic [NW-1:0] num_pulses,
   input  wire logic [CW-1:0] delay_len,
   input  wire logic [CW-1:0] pulse_len,
   input  wire logic [31:0]   timebase_hz,
   input  wire logic [2:0]    gate_mode,
   input  wire logic          pulse_polarity,
   input  wire logic          ext_timebase,
   input  wire logic          counter_gate_input,
   output logic               counter_output_pin,
   output logic               running,
   output logic [CW-1:0]      actual_delay,
   output logic [CW-1:0]      actual_width,
   output logic [CW:0]        actual_period,
   output logic [NW-1:0]      pulses_done
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic is_edge_mode(input logic [2:0] m);
      is_edge_mode = (m == GATE_RISE) || (m == GATE_FALL);
   endfunction : is_edge_mode

   // both the default setting and the nominal internal rate mean the system clock
   function automatic logic is_internal_tb(input logic [31:0] hz);
      is_internal_tb = (hz == TB_DEFAULT) || (hz == TB_INTERNAL_HZ);
   endfunction : is_internal_tb

   // clamps delay/width so neither phase vanishes and period is at least three
   function automatic logic [CW-1:0] clamp_len(input logic [CW-1:0] len,
                                               input logic [CW-1:0] other);
      logic [CW-1:0] r;
      r = (len < MIN_PHASE) ? MIN_PHASE : len;
      if ({1'b0, r} + {1'b0, ((other < MIN_PHASE) ? MIN_PHASE : other)} < {1'b0, MIN_PERIOD}
          && len >= other)
         r = MIN_PERIOD - MIN_PHASE;
      clamp_len = r;
   endfunction : clamp_len

   // ------------------------------------------------------------
   // input conditioning
   // ------------------------------------------------------------
   logic gate_lvl;
   logic gate_rise;
   logic gate_fall;
   logic tb_lvl;
   logic tb_rise;

   gptg_sync u_gate_sync
   (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .async_in  (counter_gate_input),
      .level_out (gate_lvl),
      .rise_out  (gate_rise),
      .fall_out  (gate_fall)
   );

   gptg_sync u_tb_sync
   (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .async_in  (ext_timebase),
      .level_out (tb_lvl),
      .rise_out  (tb_rise),
      .fall_out  ()
   );

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed
   {
      gptg_state_t   st;
      logic [CW-1:0] cnt;
      logic [CW-1:0] dly;
      logic [CW-1:0] wid;
      logic [NW-1:0] target;
      logic [NW-1:0] done;
      logic [2:0]    mode;
      logic          pol;
      logic          ext_sel;
      logic          out;
      logic          run;
      logic [CW:0]   per;
   } gptg_t;

   gptg_t s_reg;
   gptg_t s_next;

   logic tick;
   logic gate_ok;
   logic trig_edge;
   logic use_ext;
   logic [CW-1:0] dly_c;
   logic [CW-1:0] wid_c;

   // ------------------------------------------------------------
   // gating and timebase
   // ------------------------------------------------------------

   // external ticks are edge-detected after the synchroniser, so the
   // external rate must stay below a quarter of the system clock
   always_comb
   begin
      use_ext   = !is_internal_tb(timebase_hz);
      dly_c     = clamp_len(delay_len, pulse_len);
      wid_c     = clamp_len(pulse_len, delay_len);
      tick      = s_reg.ext_sel ? tb_rise : 1'b1;
      case (s_reg.mode)
         GATE_HIGH: gate_ok = gate_lvl;
         GATE_LOW:  gate_ok = ~gate_lvl;
         default:   gate_ok = 1'b1;
      endcase
      trig_edge = (s_reg.mode == GATE_RISE) ? gate_rise : gate_fall;
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      s_next = s_reg;
      case (s_reg.st)
         GPTG_IDLE:
         begin
            if (sw_start)
            begin
               s_next.dly     = dly_c;
               s_next.wid     = wid_c;
               s_next.target  = num_pulses;
               s_next.done    = '0;
               s_next.mode    = gate_mode;
               s_next.pol     = pulse_polarity;
               s_next.ext_sel = use_ext;
               s_next.run     = 1'b1;
               s_next.cnt     = dly_c;
               s_next.st      = is_edge_mode(gate_mode) ? GPTG_ARMED : GPTG_DELAY;
            end
         end
         GPTG_ARMED:
         begin
            // a stop while armed simply drops the pending trigger
            if (trig_edge)
            begin
               s_next.cnt = s_reg.dly;
               s_next.st  = GPTG_DELAY;
            end
         end
         GPTG_DELAY:
         begin
            if (tick && gate_ok)
            begin
               if (s_reg.cnt <= MIN_PHASE)
               begin
                  s_next.cnt = s_reg.wid;
                  s_next.st  = GPTG_PULSE;
               end
               else
                  s_next.cnt = s_reg.cnt - MIN_PHASE;
            end
         end
         GPTG_PULSE:
         begin
            if (tick && gate_ok)
            begin
               if (s_reg.cnt <= MIN_PHASE)
               begin
                  // counts finished pulses, not started ones
                  s_next.done = s_reg.done + 1'b1;
                  s_next.cnt  = s_reg.dly;
                  s_next.st   = GPTG_DELAY;
                  if (s_reg.target != PULSES_CONT && s_reg.target != PULSES_FREE
                      && s_reg.done + 1'b1 >= s_reg.target)
                  begin
                     s_next.st  = GPTG_IDLE;
                     s_next.run = 1'b0;
                  end
                  else if (is_edge_mode(s_reg.mode) && s_reg.target == PULSES_CONT)
                     s_next.st  = GPTG_ARMED;
               end
               else
                  s_next.cnt = s_reg.cnt - MIN_PHASE;
            end
         end
         default:
            s_next.st = GPTG_IDLE;
      endcase
      if (sw_stop)
      begin
         s_next.st  = GPTG_IDLE;
         s_next.run = 1'b0;
      end
      // idle and delay show the delay level
      s_next.out = (s_next.st == GPTG_PULSE) ^ s_next.pol;
      // period readback registered so the port comes straight from a flop
      s_next.per = {1'b0, s_next.dly} + {1'b0, s_next.wid};
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         s_reg      <= '0;
         s_reg.st   <= GPTG_IDLE;
         s_reg.dly  <= RST_DELAY_LEN;
         s_reg.wid  <= RST_PULSE_LEN;
         s_reg.per  <= {1'b0, RST_DELAY_LEN} + {1'b0, RST_PULSE_LEN};
      end
      else
         s_reg <= s_next;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign counter_output_pin = s_reg.out;
   assign running            = s_reg.run;
   assign actual_delay       = s_reg.dly;
   assign actual_width       = s_reg.wid;
   assign actual_period      = s_reg.per;
   assign pulses_done        = s_reg.done;

endmodule : gptg_top

// ===== test/gptg_properties.sv
`timescale 1ns/1ps
// ------------------------------
// port checks
// ------------------------------
module gptg_properties
   import gptg_pkg::*;
#(
   parameter int CW = CNT_W,
   parameter int NW = NUM_W
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic sw_start,
   input wire logic sw_stop,
   input wire logic [NW-1:0] num_pulses,
   input wire logic [CW-1:0] delay_len,
   input wire logic [CW-1:0] pulse_len,
   input wire logic [31:0] timebase_hz,
   input wire logic [2:0] gate_mode,
   input wire logic pulse_polarity,
   input wire logic ext_timebase,
   input wire logic counter_gate_input,
   input wire logic counter_output_pin,
   input wire logic running,
   input wire logic [CW-1:0] actual_delay,
   input wire logic [CW-1:0] actual_width,
   input wire logic [CW:0] actual_period,
   input wire logic [NW-1:0] pulses_done
);
   logic [NW-1:0] num_q;
   logic [2:0]    mode_q;
   logic          pol_q;
   logic          plain_q;
   logic          last_pin;
   logic [CW:0]   hold;
   wire           take = sw_start && !running && !sw_stop;
   wire           fin = num_q != PULSES_CONT && num_q != PULSES_FREE;
   // phase lengths are exact cycle counts only when ungated on the system clock
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         {num_q, mode_q, pol_q, plain_q, last_pin, hold} <= '0;
      else
      begin
         last_pin <= counter_output_pin;
         hold <= take ? '0 : (counter_output_pin != last_pin) ? (CW+1)'(1) : hold + (CW+1)'(1);
         if (take)
         begin
            num_q <= num_pulses;
            mode_q <= gate_mode;
            pol_q <= pulse_polarity;
            plain_q <= gate_mode == GATE_NONE && (timebase_hz == TB_DEFAULT || timebase_hz == TB_INTERNAL_HZ);
         end
         else if (sw_stop)
            plain_q <= 1'b0;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_frozen;
      (running && (mode_q == GATE_HIGH ? !counter_gate_input : mode_q == GATE_LOW && counter_gate_input))[*8];
   endsequence
   sequence s_edge;
      plain_q && hold != '0 && counter_output_pin != last_pin;
   endsequence
   a_first_level: assert property (take |=> counter_output_pin == $past(pulse_polarity))
      else $error("bad start level");
   a_phase_len: assert property (s_edge |-> hold == (last_pin == pol_q ? actual_delay : actual_width))
      else $error("bad phase length");
   a_start_run: assert property (take |=> running)
      else $error("start lost");
   a_finite_end: assert property ($fell(running) && !$past(sw_stop) && fin |-> pulses_done == num_q)
      else $error("bad pulse count");
   a_endless_run: assert property (running && num_q == PULSES_CONT && mode_q < GATE_RISE && !sw_stop |=> running)
      else $error("train stopped");
   a_gate_freeze: assert property (s_frozen |-> $stable(counter_output_pin))
      else $error("counted while gated");
   a_min_period: assert property (actual_delay >= MIN_PHASE && actual_width >= MIN_PHASE && actual_period >= MIN_PERIOD)
      else $error("period too short");
   a_period_sum: assert property (actual_period == actual_delay + actual_width)
      else $error("bad period");
endmodule : gptg_properties

// ===== test/gptg_far_end.sv
`timescale 1ns/1ps
// ------------------------------
// gate source and external timebase
// ------------------------------
module gptg_far_end
(
   input  wire logic clk_sys,
   input  wire logic gate_cmd,
   output logic      ext_timebase,
   output logic      counter_gate_input
);
   int div = 0;
   // an eighth of the system rate, safely below the quarter-rate limit
   always @(negedge clk_sys)
   begin
      div <= div + 1;
      ext_timebase <= div[2];
   end
   // gate edges land off both clock edges, like a real ttl source
   assign #7 counter_gate_input = gate_cmd;
endmodule : gptg_far_end

// ===== test/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
   import gptg_pkg::*;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic        sw_start = 1'b0;
   logic        sw_stop = 1'b0;
   logic [31:0] num_pulses = 32'h1;
   logic [15:0] delay_len = 16'h2;
   logic [15:0] pulse_len = 16'h2;
   logic [31:0] timebase_hz = 32'h0;
   logic [2:0]  gate_mode = 3'h0;
   logic        pulse_polarity = 1'b0;
   logic        gate_cmd = 1'b0;
   wire logic   ext_timebase, counter_gate_input, counter_output_pin, running;
   wire logic [15:0] actual_delay, actual_width;
   wire logic [16:0] actual_period;
   wire logic [31:0] pulses_done;
   int          bad_count = 0;
   int          total_checks = 0;
   logic        q[$];
   int          nt[4] = '{1, 3, 2, 2};
   int          dt[4] = '{2, 1, 0, 5};
   int          wt[4] = '{3, 2, 2, 0};
   always #25 clk_sys = !clk_sys;
   gptg_top i_dut (.*);
   gptg_far_end i_far (.clk_sys(clk_sys), .gate_cmd(gate_cmd), .ext_timebase(ext_timebase),
      .counter_gate_input(counter_gate_input));
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : tick
   task automatic start(input logic [31:0] n, input int d, input int w, input logic p, input logic [2:0] m);
      tick(1);
      {num_pulses, delay_len, pulse_len, pulse_polarity, gate_mode} = {n, d[15:0], w[15:0], p, m};
      sw_start = 1'b1;
      tick(1);
      sw_start = 1'b0;
   endtask : start
   task automatic stop;
      sw_stop = 1'b1;
      tick(2);
      sw_stop = 1'b0;
      `CHK(running, 1'b0)
   endtask : stop
   task automatic wait_idle;
      for (int k = 0; k < 400 && running !== 1'b0; k++)
         tick(1);
      `CHK(running, 1'b0)
   endtask : wait_idle
   task automatic run_plain(input int n, input int d, input int w, input logic p);
      int dd;
      int ww;
      dd = (d < 1) ? 1 : d;
      ww = (w < 1) ? 1 : w;
      q = {};
      repeat (n)
      begin
         repeat (dd) q.push_back(p);
         repeat (ww) q.push_back(!p);
      end
      q.push_back(p);
      start(n, d, w, p, GATE_NONE);
      `CHK(actual_delay, dd[15:0])
      `CHK(actual_width, ww[15:0])
      `CHK(actual_period, 17'(dd + ww))
      foreach (q[i])
      begin
         gate_cmd = 1'($urandom);
         `CHK(counter_output_pin, q[i])
         tick(1);
      end
      `CHK(pulses_done, n[31:0])
   endtask : run_plain
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      void'($urandom(32'hf8ca));
      tick(2);
      nrst = 1'b1;
      `CHK(actual_delay, RST_DELAY_LEN)
      `CHK(actual_width, RST_PULSE_LEN)
      for (int i = 0; i < 7; i++)
      begin
         timebase_hz = i[0] ? TB_INTERNAL_HZ : TB_DEFAULT;
         if (i < 4)
            run_plain(nt[i], dt[i], wt[i], i[0]);
         else
            run_plain($urandom_range(3, 1), $urandom_range(6, 1), $urandom_range(6, 2), 1'($urandom));
         tick(3);
      end
      start(PULSES_CONT, 3, 1, 1'b0, GATE_NONE);
      tick(40);
      start(PULSES_CONT, 7, 1, 1'b0, GATE_NONE);
      `CHK(actual_delay, 16'h3)
      stop();
      timebase_hz = 32'd1000;
      start(32'h1, 2, 2, 1'b0, GATE_NONE);
      tick(16);
      `CHK(running, 1'b1)
      wait_idle();
      timebase_hz = TB_DEFAULT;
      for (int m = 1; m < 5; m++)
      begin
         gate_cmd = !m[0];
         tick(6);
         start(32'h1, 2, 2, 1'b0, m[2:0]);
         tick(30);
         `CHK(pulses_done, 32'h0)
         gate_cmd = m[0];
         wait_idle();
      end
      start(PULSES_CONT, 2, 2, 1'b0, GATE_RISE);
      for (int k = 1; k < 4; k++)
      begin
         gate_cmd = 1'b1;
         tick(15);
         gate_cmd = 1'b0;
         tick(15);
         `CHK(pulses_done, k[31:0])
      end
      stop();
      gate_cmd = 1'b1;
      start(PULSES_FREE, 2, 2, 1'b0, GATE_FALL);
      tick(10);
      gate_cmd = 1'b0;
      tick(80);
      `CHK(pulses_done > 32'd10, 1'b1)
      stop();
      wrap_up();
   end
   initial
   begin
      #(20000 * 50);
      bad_count++;
      wrap_up();
   end
endmodule : tb
bind gptg_top gptg_properties #(.CW(CW), .NW(NW)) i_props (.*);
